/* rtl/ssa_cfg.svh */
// Offsets, field positions, reset values and timing counts of the slope converter control.
`ifndef SSA_CFG_SVH
`define SSA_CFG_SVH
`define SSA_OFF_MODE      12'h000
`define SSA_OFF_TRIM      12'h004
`define SSA_OFF_CAP0      12'h008
`define SSA_OFF_CAP1      12'h00c
`define SSA_OFF_CAP2      12'h010
`define SSA_OFF_CAP3      12'h014
`define SSA_OFF_IRQ_STAT  12'h018
`define SSA_OFF_IRQ_CLR   12'h01c
`define SSA_OFF_IRQ_EN    12'h020
`define SSA_OFF_STATUS    12'h024
`define SSA_MODE_MUX_LO   0
`define SSA_MODE_MUX_HI   1
`define SSA_MODE_RATE     7
`define SSA_MODE_RST      8'h00
`define SSA_TRIM_RST      3'h0
`define SSA_CNT_MAX       12'hfff
`define SSA_CNT_ZERO      12'h000
`define SSA_IRQ_CAP0      0
`define SSA_IRQ_DONE      4
`define SSA_IRQ_FAULT     5
`endif

/* rtl/ssa_pkg.sv */
// Types shared by the slope converter control files.
package ssa_pkg;
    typedef logic [11:0] ssa_count_t;
    typedef struct packed {
        logic       rate_fast;
        logic [1:0] aux_sel;
    } ssa_mode_s;
    typedef enum logic [2:0] {
        SSA_IDLE  = 3'b001,
        SSA_RESET = 3'b010,
        SSA_COUNT = 3'b100
    } ssa_state_e;
endpackage

/* rtl/ssa_capture.sv */
// One capture channel: latches the shared count on the first comparator trip.
`timescale 1ns/1ns
`include "ssa_cfg.svh"
module ssa_capture (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Conversion control
    input  wire logic              restart,
    input  wire logic              counting,
    input  wire ssa_pkg::ssa_count_t count,
    input  wire logic              comp_trip,
    // Result
    output ssa_pkg::ssa_count_t    result,
    output logic                   tripped,
    output logic                   captured
);
    ssa_pkg::ssa_count_t run_val;
    logic                comp_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_q <= 1'b0;
        end else begin
            comp_q <= comp_trip;
        end
    end

    assign captured = counting && !tripped && comp_trip && !comp_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tripped <= 1'b0;
            run_val <= `SSA_CNT_ZERO;
        end else if (restart) begin
            tripped <= 1'b0;
            run_val <= `SSA_CNT_ZERO;
        end else if (captured) begin
            tripped <= 1'b1;
            run_val <= count;
        end
    end

    // The reported value updates at restart; an untripped channel reports zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= `SSA_CNT_ZERO;
        end else if (restart) begin
            result <= tripped ? run_val : `SSA_CNT_ZERO;
        end
    end
endmodule // ssa_capture

/* rtl/ssa_ctrl.sv */
// Single slope converter control with APB registers.
//
// Contract
// - Aux select 11 picks internal reference.
// - One shared timer; per-channel capture on trip.
// - Timer and captures are twelve bits.
// - Sync pulse discharges ramp, restarts timer.
// - Rate bit clear counts half rate.
// - Count saturates at its twelve-bit maximum.
// - Window follows sync spacing, single or double.
// - No trip before restart reports zero.
// - Three-bit trim selects eight current steps.
// - Trim resets to zero.
// - Sample-and-hold captures on sync falling edge.
// - Current sense trip drives fault line low.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`include "ssa_cfg.svh"
module ssa_ctrl (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog side
    input  wire logic        period_sync_pulse,
    input  wire logic [3:0]  comp_trip,
    input  wire logic        sense_below_trip,
    output logic             aux_select_lo,
    output logic             aux_select_hi,
    output logic             ramp_discharge,
    output logic [2:0]       ramp_current_trim,
    output logic             sense_hold_strobe,
    output logic             fault_trip_n,
    // Interrupt
    output logic             irq
);
    ssa_pkg::ssa_mode_s  mode;
    ssa_pkg::ssa_state_e state;
    ssa_pkg::ssa_count_t count;
    ssa_pkg::ssa_count_t cap [4];
    logic [3:0]          tripped;
    logic [3:0]          captured;
    logic [5:0]          irq_stat;
    logic [5:0]          irq_en;
    logic                sync_q;
    logic                half_en;
    logic                restart;
    logic                sync_fall;
    logic                sense_q;
    logic                wr;
    logic                rd;

    ////////////////////////////////////////////////////////////////////////////
    // Bus access.
    assign pready  = 1'b1;
    assign wr      = psel && penable && pwrite;
    assign rd      = psel && !pwrite;
    assign pslverr = 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= '0;
        end else if (wr && paddr == `SSA_OFF_MODE) begin
            mode.aux_sel   <= {pwdata[`SSA_MODE_MUX_HI], pwdata[`SSA_MODE_MUX_LO]};
            mode.rate_fast <= pwdata[`SSA_MODE_RATE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_current_trim <= `SSA_TRIM_RST;
        end else if (wr && paddr == `SSA_OFF_TRIM) begin
            ramp_current_trim <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en <= 6'h00;
        end else if (wr && paddr == `SSA_OFF_IRQ_EN) begin
            irq_en <= pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd && !penable) begin
            unique case (paddr)
                `SSA_OFF_MODE:     prdata <= {24'h000000, mode.rate_fast, 5'h00, mode.aux_sel};
                `SSA_OFF_TRIM:     prdata <= {29'h00000000, ramp_current_trim};
                `SSA_OFF_CAP0:     prdata <= {20'h00000, cap[0]};
                `SSA_OFF_CAP1:     prdata <= {20'h00000, cap[1]};
                `SSA_OFF_CAP2:     prdata <= {20'h00000, cap[2]};
                `SSA_OFF_CAP3:     prdata <= {20'h00000, cap[3]};
                `SSA_OFF_IRQ_STAT: prdata <= {26'h0000000, irq_stat};
                `SSA_OFF_IRQ_EN:   prdata <= {26'h0000000, irq_en};
                `SSA_OFF_STATUS:   prdata <= {16'h0000, tripped, count};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Aux multiplexer select.
    assign aux_select_lo = mode.aux_sel[0];
    assign aux_select_hi = mode.aux_sel[1];

    ////////////////////////////////////////////////////////////////////////////
    // Conversion timer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q <= 1'b0;
        end else begin
            sync_q <= period_sync_pulse;
        end
    end

    // Every sync pulse starts a window, so double update shortens it by itself.
    assign restart   = period_sync_pulse && !sync_q;
    assign sync_fall = !period_sync_pulse && sync_q;
    assign ramp_discharge    = period_sync_pulse;
    assign sense_hold_strobe = sync_fall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_en <= 1'b0;
        end else if (period_sync_pulse) begin
            half_en <= 1'b0;
        end else begin
            half_en <= !half_en;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ssa_pkg::SSA_IDLE;
        end else begin
            unique case (state)
                ssa_pkg::SSA_IDLE:  if (period_sync_pulse) state <= ssa_pkg::SSA_RESET;
                ssa_pkg::SSA_RESET: if (!period_sync_pulse) state <= ssa_pkg::SSA_COUNT;
                ssa_pkg::SSA_COUNT: if (period_sync_pulse) state <= ssa_pkg::SSA_RESET;
                default:            state <= ssa_pkg::SSA_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= `SSA_CNT_ZERO;
        end else if (period_sync_pulse) begin
            count <= `SSA_CNT_ZERO;
        end else if (state == ssa_pkg::SSA_COUNT && count != `SSA_CNT_MAX
                     && (mode.rate_fast || half_en)) begin
            count <= count + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture channels.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            ssa_capture u_cap (
                .pclk      (pclk),
                .presetn   (presetn),
                .restart   (restart),
                .counting  (state == ssa_pkg::SSA_COUNT),
                .count     (count),
                .comp_trip (comp_trip[gi]),
                .result    (cap[gi]),
                .tripped   (tripped[gi]),
                .captured  (captured[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Current sense fault line.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_q      <= 1'b0;
            fault_trip_n <= 1'b1;
        end else begin
            sense_q      <= sense_below_trip;
            fault_trip_n <= !sense_below_trip;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over a clear in the same cycle.
    logic [5:0] irq_set;
    assign irq_set = {sense_below_trip && !sense_q, restart, captured};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= 6'h00;
        end else begin
            irq_stat <= (irq_stat & ~((wr && paddr == `SSA_OFF_IRQ_CLR) ? pwdata[5:0] : 6'h00)) | irq_set;
        end
    end

    assign irq = |(irq_stat & irq_en);

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_sync_clears: assert property (@(posedge pclk) disable iff (!presetn)
        period_sync_pulse |=> count == `SSA_CNT_ZERO) else $error("count not cleared by sync");
    a_count_sat: assert property (@(posedge pclk) disable iff (!presetn)
        count == `SSA_CNT_MAX && !period_sync_pulse |=> count == `SSA_CNT_MAX) else $error("count wrapped");
    a_slow_rate: assert property (@(posedge pclk) disable iff (!presetn)
        !mode.rate_fast && $past(!mode.rate_fast) && !period_sync_pulse && count != `SSA_CNT_ZERO
        |=> count == $past(count) || $past(count) == $past(count, 2)) else $error("slow rate too fast");
    a_fast_rate: assert property (@(posedge pclk) disable iff (!presetn)
        mode.rate_fast && state == ssa_pkg::SSA_COUNT && !period_sync_pulse && count != `SSA_CNT_MAX
        |=> count == $past(count) + 12'h001) else $error("fast rate stalled");
    a_aux_select: assert property (@(posedge pclk) disable iff (!presetn)
        {aux_select_hi, aux_select_lo} == mode.aux_sel) else $error("aux select mismatch");
    a_trim_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `SSA_OFF_TRIM |=> ramp_current_trim == $past(pwdata[2:0])) else $error("trim not written");
    a_hold_edge: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(period_sync_pulse) |-> sense_hold_strobe) else $error("hold strobe missing");
    a_fault_low: assert property (@(posedge pclk) disable iff (!presetn)
        sense_below_trip |=> !fault_trip_n) else $error("fault line not low");
    a_zero_report: assert property (@(posedge pclk) disable iff (!presetn)
        restart && !tripped[0] |=> cap[0] == `SSA_CNT_ZERO) else $error("untripped channel not zero");
    a_first_trip: assert property (@(posedge pclk) disable iff (!presetn)
        tripped[1] && !restart |=> $stable(tripped[1])) else $error("second trip taken");
    a_trim_reset: assert property (@(posedge pclk) $rose(presetn) |-> ramp_current_trim == `SSA_TRIM_RST)
        else $error("trim not reset");
    a_shared_cap: assert property (@(posedge pclk) disable iff (!presetn)
        captured[2] |=> tripped[2]) else $error("capture not marked");

    ////////////////////////////////////////////////////////////////////////////
    // Bus and register checks.
    a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
        psel
        |-> pready) else $error("ready not high");

    a_no_slverr: assert property (@(posedge pclk) disable iff (!presetn)
        psel
        |-> !pslverr) else $error("slave error raised");

    a_read_mode: assert property (@(posedge pclk) disable iff (!presetn)
        rd && !penable && paddr == `SSA_OFF_MODE
        |=> prdata == {24'h000000, $past(mode.rate_fast), 5'h00, $past(mode.aux_sel)}) else $error("mode read wrong");

    a_read_trim: assert property (@(posedge pclk) disable iff (!presetn)
        rd && !penable && paddr == `SSA_OFF_TRIM
        |=> prdata[2:0] == $past(ramp_current_trim)) else $error("trim read wrong");

    a_read_cap0: assert property (@(posedge pclk) disable iff (!presetn)
        rd && !penable && paddr == `SSA_OFF_CAP0
        |=> prdata[11:0] == $past(cap[0])) else $error("capture read wrong");

    a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
        rd && !penable
        |=> prdata[31:16] == 16'h0000) else $error("upper read bits set");

    a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `SSA_OFF_MODE
        |=> mode.rate_fast == $past(pwdata[`SSA_MODE_RATE])) else $error("rate bit not written");

    a_irq_en_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `SSA_OFF_IRQ_EN
        |=> irq_en == $past(pwdata[5:0])) else $error("irq enable not written");

    a_irq_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        irq_set[`SSA_IRQ_DONE]
        |=> irq_stat[`SSA_IRQ_DONE]) else $error("restart event lost");

    a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `SSA_OFF_IRQ_CLR && pwdata[`SSA_IRQ_DONE] && !irq_set[`SSA_IRQ_DONE]
        |=> !irq_stat[`SSA_IRQ_DONE]) else $error("restart flag not cleared");

    a_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
        irq_en == 6'h00
        |-> !irq) else $error("irq with nothing enabled");

    ////////////////////////////////////////////////////////////////////////////
    // Conversion checks.
    a_discharge_pin: assert property (@(posedge pclk) disable iff (!presetn)
        period_sync_pulse
        |-> ramp_discharge) else $error("ramp not discharged");

    a_hold_once: assert property (@(posedge pclk) disable iff (!presetn)
        sense_hold_strobe
        |=> !sense_hold_strobe) else $error("hold strobe too long");

    a_strobe_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        period_sync_pulse
        |-> !sense_hold_strobe) else $error("hold strobe during sync");

    a_restart_state: assert property (@(posedge pclk) disable iff (!presetn)
        restart
        |=> state == ssa_pkg::SSA_RESET) else $error("restart not taken");

    a_count_start: assert property (@(posedge pclk) disable iff (!presetn)
        state == ssa_pkg::SSA_RESET && !period_sync_pulse
        |=> state == ssa_pkg::SSA_COUNT && count == `SSA_CNT_ZERO) else $error("count start wrong");

    a_idle_count: assert property (@(posedge pclk) disable iff (!presetn)
        state == ssa_pkg::SSA_IDLE
        |-> count == `SSA_CNT_ZERO) else $error("count moved before sync");

    a_fault_high: assert property (@(posedge pclk) disable iff (!presetn)
        !sense_below_trip
        |=> fault_trip_n) else $error("fault line stuck low");

    a_cap_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !restart
        |=> $stable(cap[1])) else $error("capture changed mid window");

    a_cap_hold_aux: assert property (@(posedge pclk) disable iff (!presetn)
        !restart
        |=> $stable(cap[3])) else $error("aux capture changed mid window");

    a_trips_cleared: assert property (@(posedge pclk) disable iff (!presetn)
        restart
        |=> tripped == 4'h0) else $error("trip marks not cleared");

    a_state_onehot: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1
        |-> $onehot(state)) else $error("state not one-hot");

    a_half_sync: assert property (@(posedge pclk) disable iff (!presetn)
        period_sync_pulse
        |=> !half_en) else $error("half rate phase not reset");

    a_trim_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && paddr == `SSA_OFF_TRIM)
        |=> $stable(ramp_current_trim)) else $error("trim changed without write");

    a_aux_ref: assert property (@(posedge pclk) disable iff (!presetn)
        mode.aux_sel == 2'b11
        |-> aux_select_hi && aux_select_lo) else $error("reference not selected");
endmodule // ssa_ctrl

/* tb/ssa_ramp_model.sv */
// Behavioural ramp, comparators and aux multiplexer at the far side.
`timescale 1ns/1ns
module ssa_ramp_model (
    // Clock and ramp control
    input  wire logic        pclk,
    input  wire logic        ramp_discharge,
    input  wire logic [1:0]  aux_sel,
    input  wire logic        glitch,
    input  wire logic [2:0]  trim,
    // Levels in ramp cycles: ch1, ch2, ch3, aux0, aux1, aux2, reference
    input  wire logic [12:0] lvl [7],
    // Comparator outputs
    output logic [3:0]       comp_trip
);
    logic [12:0] ramp;
    logic [12:0] aux_lvl;
    always_ff @(posedge pclk) begin
        if (ramp_discharge) begin
            ramp <= 13'h0000;
        end else if (ramp != 13'h1fff) begin
            ramp <= ramp + 13'h0001;
        end
    end
    // A larger trim charges faster, so the reference is crossed sooner.
    assign aux_lvl = (aux_sel == 2'b11) ? lvl[6] - {6'h00, trim, 4'h0} : lvl[3 + aux_sel];
    // A commanded glitch drops the first comparator once after it trips.
    assign comp_trip[0] = (ramp >= lvl[0]) && !(glitch && ramp == lvl[0] + 13'h0014);
    assign comp_trip[3:1] = {ramp >= aux_lvl, ramp >= lvl[2], ramp >= lvl[1]};
endmodule // ssa_ramp_model

/* tb/testbench.sv */
// Self-checking bench for the slope converter control.
`timescale 1ns/1ns
`include "ssa_cfg.svh"
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sync, sense, glitch;
    logic        aux_lo, aux_hi, disch, strobe, fault_n, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  comp;
    logic [2:0]  trim;
    logic [12:0] lvl [7];
    int          miscompares, check_count, strobes, e;
    ssa_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .period_sync_pulse(sync), .comp_trip(comp), .sense_below_trip(sense), .aux_select_lo(aux_lo),
        .aux_select_hi(aux_hi), .ramp_discharge(disch), .ramp_current_trim(trim),
        .sense_hold_strobe(strobe), .fault_trip_n(fault_n), .irq(irq));
    ssa_ramp_model i_model (.pclk(pclk), .ramp_discharge(disch), .aux_sel({aux_hi, aux_lo}),
        .glitch(glitch), .trim(trim), .lvl(lvl), .comp_trip(comp));
    ////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(negedge pclk) strobes += strobe;
    initial begin
        repeat (30000) @(posedge pclk);
        miscompares++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic conv(input int n);
        strobes = 0;
        sync <= 1'b1;
        repeat (4) @(posedge pclk);
        sync <= 1'b0;
        repeat (n) begin
            @(posedge pclk);
            chk("ramp_discharge", sync, disch);
        end
        sync <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("hold_strobe", 1, strobes);
    endtask
    function automatic int exp_cap(int l, int n, logic fast);
        int c;
        c = fast ? l : l / 2;
        if (l > n) return 0;
        return (c > 4095) ? 4095 : c;
    endfunction
    function automatic logic near(int x, logic [11:0] got);
        return (x == 0) ? (got == 12'h000) : ((got + 14'h0002 >= x) && (got <= x + 2));
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, sense} = 5'h00;
        {paddr, pwdata, sync, glitch} = {12'h000, 32'h0, 2'b01};
        {miscompares, check_count} = 0;
        foreach (lvl[c]) lvl[c] = 13'h0010;
        void'($urandom(86));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 'h2c; a += 4) begin
            apb(1'b0, a[11:0], 32'h0);
            chk("reset_reg", 0, rd);
        end
        chk("trim_pin", 0, trim);
        for (int i = 0; i < 3; i++) begin
            e = (i == 0) ? 7 : $urandom_range(6, 0);
            apb(1'b1, `SSA_OFF_TRIM, e);
            apb(1'b0, `SSA_OFF_TRIM, 32'h0);
            chk("trim_reg", e, rd);
            chk("trim_pin", e, trim);
        end
        apb(1'b1, `SSA_OFF_TRIM, 32'h0);
        for (int i = 0; i < 4; i++) begin
            foreach (lvl[c]) lvl[c] = $urandom_range(500, 10);
            if (i == 3) lvl[1] = 13'd700;
            apb(1'b1, `SSA_OFF_MODE, {24'h0, i[0], 5'h00, i[1:0]});
            conv(600);
            chk("aux_select", i[1:0], {aux_hi, aux_lo});
            for (int c = 0; c < 4; c++) begin
                apb(1'b0, `SSA_OFF_CAP0 + 12'(4 * c), 32'h0);
                e = exp_cap((c < 3) ? lvl[c] : (i == 3) ? lvl[6] : lvl[3 + i], 600, i[0]);
                chk("capture", 1, near(e, rd[11:0]));
            end
        end
        lvl[6] = 13'd500;
        apb(1'b1, `SSA_OFF_TRIM, 32'h0);
        apb(1'b1, `SSA_OFF_MODE, 32'h83);
        e = 600 * 25 / 35;
        for (int k = 0; k < 8; k++) begin
            conv(600);
            apb(1'b0, `SSA_OFF_CAP3, 32'h0);
            if (rd[11:0] <= e) break;
            apb(1'b1, `SSA_OFF_TRIM, k + 1);
        end
        apb(1'b0, `SSA_OFF_TRIM, 32'h0);
        chk("cal_trim", 5, rd);
        lvl[0] = 13'd4150;
        apb(1'b1, `SSA_OFF_MODE, 32'h80);
        conv(4200);
        apb(1'b0, `SSA_OFF_CAP0, 32'h0);
        chk("capture_sat", 1, near(4095, rd[11:0]));
        apb(1'b1, `SSA_OFF_IRQ_EN, 32'h10);
        #1 chk("irq_restart", 1, irq);
        apb(1'b1, `SSA_OFF_IRQ_CLR, 32'h10);
        #1 chk("irq_cleared", 0, irq);
        @(posedge pclk);
        sense <= 1'b1;
        #1 chk("fault_n", 1, fault_n);
        @(posedge pclk);
        #1 chk("fault_n", 0, fault_n);
        chk("irq_masked", 0, irq);
        apb(1'b1, `SSA_OFF_IRQ_EN, 32'h20);
        #1 chk("irq_fault", 1, irq);
        apb(1'b1, `SSA_OFF_IRQ_CLR, 32'h20);
        #1 chk("irq_cleared", 0, irq);
        end_of_test();
    end
endmodule // testbench
